// *** logic/tie89_gate_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface tie89_gate_if;
    logic [15:0] one_shot_enable;
    logic [5:0] compare_enable;
    modport regs (output one_shot_enable, output compare_enable);
    modport gate (input one_shot_enable, input compare_enable);
endinterface : tie89_gate_if
`default_nettype wire

// *** logic/tie89_irq_gate.sv ***
`timescale 1ns/10ps
`default_nettype none
module tie89_irq_gate (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Enables from the register file
    tie89_gate_if.gate en,
    // Flags from the status logic
    input wire logic [15:0] one_shot_flag_i,
    input wire logic [5:0] compare_flag_i,
    // Requests to the interrupt controller
    output logic [15:0] one_shot_irq_o,
    output logic [5:0] compare_irq_o
);
    logic [15:0] one_shot_irq_r;
    logic [15:0] one_shot_irq_nxt;
    logic [5:0] compare_irq_r;
    logic [5:0] compare_irq_nxt;

    always_comb begin
        one_shot_irq_nxt = one_shot_flag_i & en.one_shot_enable;
        compare_irq_nxt = compare_flag_i & en.compare_enable;
    end

    // Registered so requests are glitch free; one cycle of lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            one_shot_irq_r <= 16'h0000;
            compare_irq_r <= 6'h00;
        end else begin
            one_shot_irq_r <= one_shot_irq_nxt;
            compare_irq_r <= compare_irq_nxt;
        end
    end

    assign one_shot_irq_o = one_shot_irq_r;
    assign compare_irq_o = compare_irq_r;

    chk_oneshot_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 one_shot_irq_o == ($past(one_shot_flag_i) & $past(en.one_shot_enable)))
        else $error("one-shot request not flag AND enable");
    chk_compare_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 compare_irq_o == ($past(compare_flag_i) & $past(en.compare_enable)))
        else $error("compare request not flag AND enable");
    chk_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (en.one_shot_enable == 16'h0000 && en.compare_enable == 6'h00)
        |=> (one_shot_irq_o == 16'h0000 && compare_irq_o == 6'h00))
        else $error("request while all enables clear");
    cov_oneshot_irq: cover property (@(posedge clk_i) disable iff (rst_i)
        one_shot_irq_o != 16'h0000);
    cov_compare_irq: cover property (@(posedge clk_i) disable iff (rst_i)
        compare_irq_o != 6'h00);
    cov_flag_blocked: cover property (@(posedge clk_i) disable iff (rst_i)
        (compare_flag_i != 6'h00) && (en.compare_enable == 6'h00));
endmodule : tie89_irq_gate
`default_nettype wire

// *** logic/tie89_pkg.sv ***
package tie89_pkg;
    // Register word addresses (byte offsets, word aligned)
    localparam logic [3:0] ADDR_ONE_SHOT_IRQ_ENABLE_CH8 = 4'h0;
    localparam logic [3:0] ADDR_COMPARE_IRQ_ENABLE_CH9 = 4'h4;
    // Field layout
    localparam int ONE_SHOT_BITS = 16;
    localparam int COMPARE_BITS = 6;
    localparam int REG_WIDTH = 16;
    // Reset values
    localparam logic [15:0] ONE_SHOT_ENABLE_RESET = 16'h0000;
    localparam logic [5:0] COMPARE_ENABLE_RESET = 6'h00;
    // Writable mask of the channel-9 register
    localparam logic [15:0] COMPARE_WRITE_MASK = 16'h003F;
endpackage : tie89_pkg

// *** logic/tie89_top.sv ***
// What this block does
// - The 16-bit channel-8 enable register's bit n gates one-shot flag n, P at 15 to A at 0.
// - A channel-8 request is high only in the cycle after its flag and its enable were both 1.
// - All sixteen channel-8 enables reset to 0 and are read/write.
// - A channel-9 enable register whose bits 5..0 are read/write and gate compare flags F..A.
// - A channel-9 request is high only in the cycle after its flag and its enable were both 1.
// - All six channel-9 enables reset to 0.
// - Channel-9 bits 15..6 are read-only and always read 0.
`timescale 1ns/10ps
`default_nettype none
module tie89_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Status flags from the timer channels
    input wire logic [15:0] one_shot_flag_i,
    input wire logic [5:0] compare_flag_i,
    // Interrupt requests
    output logic [15:0] one_shot_irq_o,
    output logic [5:0] compare_irq_o
);
    tie89_gate_if gate_bus ();

    logic [15:0] one_shot_en_r;
    logic [15:0] one_shot_en_nxt;
    logic [5:0] compare_en_r;
    logic [5:0] compare_en_nxt;
    logic ack_r;
    logic ack_nxt;
    logic err_r;
    logic err_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic req;
    logic hit8;
    logic hit9;

    function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [15:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : lane_merge

    // New request only when no answer is pending, so each cycle gets one ack or err
    assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    assign hit8 = (wb_adr_i == tie89_pkg::ADDR_ONE_SHOT_IRQ_ENABLE_CH8);
    assign hit9 = (wb_adr_i == tie89_pkg::ADDR_COMPARE_IRQ_ENABLE_CH9);

    always_comb begin
        one_shot_en_nxt = one_shot_en_r;
        compare_en_nxt = compare_en_r;
        ack_nxt = 1'b0;
        err_nxt = 1'b0;
        dat_nxt = dat_r;
        if (req) begin
            if (hit8) begin
                ack_nxt = 1'b1;
                if (wb_we_i) begin
                    one_shot_en_nxt = lane_merge(one_shot_en_r, wb_dat_i, wb_sel_i);
                end else begin
                    dat_nxt = {16'h0000, one_shot_en_r};
                end
            end else if (hit9) begin
                ack_nxt = 1'b1;
                if (wb_we_i) begin
                    // Reserved bits dropped whatever software writes
                    compare_en_nxt = 6'(lane_merge({10'h000, compare_en_r}, wb_dat_i,
                        wb_sel_i) & tie89_pkg::COMPARE_WRITE_MASK);
                end else begin
                    dat_nxt = {26'h0000000, compare_en_r};
                end
            end else begin
                err_nxt = 1'b1;
                dat_nxt = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            one_shot_en_r <= tie89_pkg::ONE_SHOT_ENABLE_RESET;
            compare_en_r <= tie89_pkg::COMPARE_ENABLE_RESET;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            one_shot_en_r <= one_shot_en_nxt;
            compare_en_r <= compare_en_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = dat_r;
    assign gate_bus.one_shot_enable = one_shot_en_r;
    assign gate_bus.compare_enable = compare_en_r;

    tie89_irq_gate i_tie89_irq_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en(gate_bus.gate),
        .one_shot_flag_i(one_shot_flag_i),
        .compare_flag_i(compare_flag_i),
        .one_shot_irq_o(one_shot_irq_o),
        .compare_irq_o(compare_irq_o)
    );

    chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && $past(hit9) && !$past(wb_we_i)) |-> wb_dat_o[31:6] == 26'h0000000)
        else $error("reserved channel-9 bits read non-zero");
    chk_ch8_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit8 && wb_we_i && wb_sel_i[1:0] == 2'b11)
        |=> one_shot_en_r == $past(wb_dat_i[15:0]))
        else $error("channel-8 write not stored");
    chk_ch9_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit9 && wb_we_i && wb_sel_i[0]) |=> compare_en_r == $past(wb_dat_i[5:0]))
        else $error("channel-9 write not stored");
    chk_reset_clear: assert property (@(posedge clk_i)
        (!rst_i && $past(rst_i)) |-> (one_shot_en_r == 16'h0000 && compare_en_r == 6'h00))
        else $error("enables not clear after reset");
    chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    chk_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && (hit8 || hit9)) |=> wb_ack_o)
        else $error("mapped access not acked next cycle");
    cov_ch8_write: cover property (@(posedge clk_i) disable iff (rst_i)
        req && hit8 && wb_we_i);
    cov_unmapped: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);

    // Read path and lane merge, checked per register
    chk_ch8_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit8 && !wb_we_i) |=> wb_dat_o == {16'h0000, $past(one_shot_en_r)})
        else $error("channel-8 read data wrong");
    chk_ch9_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit9 && !wb_we_i) |=> wb_dat_o == {26'h0000000, $past(compare_en_r)})
        else $error("channel-9 read data wrong");
    chk_ch8_low_lane: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit8 && wb_we_i) |=> one_shot_en_r[7:0] ==
        ($past(wb_sel_i[0]) ? $past(wb_dat_i[7:0]) : $past(one_shot_en_r[7:0])))
        else $error("channel-8 low lane merged wrong");
    chk_ch8_high_lane: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit8 && wb_we_i) |=> one_shot_en_r[15:8] ==
        ($past(wb_sel_i[1]) ? $past(wb_dat_i[15:8]) : $past(one_shot_en_r[15:8])))
        else $error("channel-8 high lane merged wrong");
    chk_ch9_lane_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit9 && wb_we_i && !wb_sel_i[0]) |=> $stable(compare_en_r))
        else $error("channel-9 changed without its byte lane");
    chk_ch8_keeps_ch9: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit8 && wb_we_i) |=> $stable(compare_en_r))
        else $error("channel-8 write disturbed channel-9");
    chk_ch9_keeps_ch8: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && hit9 && wb_we_i) |=> $stable(one_shot_en_r))
        else $error("channel-9 write disturbed channel-8");
    chk_read_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i) |=> ($stable(one_shot_en_r) && $stable(compare_en_r)))
        else $error("read changed an enable register");

    // Error path: unmapped offsets answer err and leave state alone
    chk_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !hit8 && !hit9) |=> (wb_err_o && !wb_ack_o && wb_dat_o == 32'h00000000))
        else $error("unmapped access not answered with err");
    chk_err_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !hit8 && !hit9) |=> ($stable(one_shot_en_r) && $stable(compare_en_r)))
        else $error("unmapped access changed an enable register");
    chk_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    chk_no_stray_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> (!wb_ack_o && !wb_err_o))
        else $error("answer without a taken request");
    // Read data must hold until the next read or unmapped access so a slow master still sees it
    chk_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(req && (!wb_we_i || !(hit8 || hit9))) |=> $stable(wb_dat_o))
        else $error("read data moved without a read");

    // Requests leave reset quiet, whatever the flags are doing
    chk_irq_reset_quiet: assert property (@(posedge clk_i)
        (!rst_i && $past(rst_i)) |-> (one_shot_irq_o == 16'h0000 && compare_irq_o == 6'h00))
        else $error("request high right after reset");

    // Per-line checks, so a failure points at one lane
    for (genvar i = 0; i < 16; i++) begin : g_one_shot_chk
        chk_one_shot_line: assert property (@(posedge clk_i) disable iff (rst_i)
            one_shot_irq_o[i] |-> ($past(one_shot_flag_i[i]) && $past(one_shot_en_r[i])))
            else $error("one-shot line high without flag and enable");
        chk_one_shot_mute: assert property (@(posedge clk_i) disable iff (rst_i)
            !one_shot_en_r[i] |=> !one_shot_irq_o[i])
            else $error("one-shot line high with enable clear");
        chk_one_shot_follow: assert property (@(posedge clk_i) disable iff (rst_i)
            (one_shot_flag_i[i] && one_shot_en_r[i]) |=> one_shot_irq_o[i])
            else $error("one-shot line late");
    end
    for (genvar i = 0; i < 6; i++) begin : g_compare_chk
        chk_compare_line: assert property (@(posedge clk_i) disable iff (rst_i)
            compare_irq_o[i] |-> ($past(compare_flag_i[i]) && $past(compare_en_r[i])))
            else $error("compare line high without flag and enable");
        chk_compare_mute: assert property (@(posedge clk_i) disable iff (rst_i)
            !compare_en_r[i] |=> !compare_irq_o[i])
            else $error("compare line high with enable clear");
        chk_compare_follow: assert property (@(posedge clk_i) disable iff (rst_i)
            (compare_flag_i[i] && compare_en_r[i]) |=> compare_irq_o[i])
            else $error("compare line late");
    end
endmodule : tie89_top
`default_nettype wire

// *** verification/tie89_irq_sink.sv ***
`timescale 1ns/10ps
`default_nettype none
// Interrupt controller stand-in: remembers every request line seen high since the last reset
module tie89_irq_sink (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Requests from the block
    input wire logic [21:0] irq_i,
    // Lines seen high since reset
    output logic [21:0] seen_o
);
    // Sticky so a one-cycle stray request is never missed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_o <= 22'h000000;
        end else begin
            seen_o <= seen_o | irq_i;
        end
    end
endmodule : tie89_irq_sink
`default_nettype wire

// *** verification/tie89_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tie89_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic ack, err;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] s;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] rd, d;
    logic [15:0] osf = 16'h0000;
    logic [15:0] osi;
    logic [15:0] en8 = 16'h0000;
    logic [5:0] cmf = 6'h00;
    logic [5:0] cmi;
    logic [5:0] en9 = 6'h00;
    logic [21:0] seen;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int errors = 0;
    int total_checks = 0;
    int seed = 75;
    tie89_top i_tie89_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
        .wb_ack_o(ack), .wb_err_o(err), .one_shot_flag_i(osf), .compare_flag_i(cmf),
        .one_shot_irq_o(osi), .compare_irq_o(cmi));
    tie89_irq_sink i_tie89_irq_sink (.clk_i(clk_i), .rst_i(rst_i), .irq_i({cmi, osi}),
        .seen_o(seen));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    // Expected reply word: bit 32 is err, low bits the read data
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd,
                      input logic [3:0] ws, input logic [32:0] ex);
        int k;
        exp_q.push_back(ex);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= wd;
        sel <= ws;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
        if (ack !== 1'b1 && err !== 1'b1) begin
            errors++;
            end_sim();
        end
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Reply watcher, pre-edge values at the answering edge
    always @(posedge clk_i) begin
        if (ack === 1'b1 || err === 1'b1) begin
            e = exp_q.pop_front();
            `CHK("err", e[32], err)
            if (we === 1'b0) `CHK("rdata", e[31:0], rd)
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        osf <= 16'hFFFF;
        cmf <= 6'h3F;
        @(posedge clk_i);
        wb(1'b0, 4'h0, 32'h00000000, 4'hF, 33'h000000000);
        wb(1'b0, 4'h4, 32'h00000000, 4'hF, 33'h000000000);
        `CHK("masked_seen", 22'h000000, seen)
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            s = 4'($random(seed));
            if (s[0]) en8[7:0] = d[7:0];
            if (s[1]) en8[15:8] = d[15:8];
            wb(1'b1, 4'h0, d, s, 33'h000000000);
            if (s[0]) en9 = d[5:0];
            wb(1'b1, 4'h4, d & 32'h0000003F, s, 33'h000000000);
            wb(1'b0, 4'h0, 32'h00000000, 4'hF, {17'h00000, en8});
            wb(1'b0, 4'h4, 32'h00000000, 4'hF, {27'h0000000, en9});
            osf <= 16'($random(seed));
            cmf <= 6'($random(seed));
            repeat (2) @(posedge clk_i);
            `CHK("one_shot_irq", osf & en8, osi)
            `CHK("compare_irq", cmf & en9, cmi)
        end
        $display("test random masks done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        en8 = 16'h0000;
        en9 = 6'h00;
        @(posedge clk_i);
        `CHK("one_shot_irq", 16'h0000, osi)
        `CHK("compare_irq", 6'h00, cmi)
        wb(1'b0, 4'h0, 32'h00000000, 4'hF, 33'h000000000);
        wb(1'b0, 4'h4, 32'h00000000, 4'hF, 33'h000000000);
        $display("test mid-run reset done");
        wb(1'b1, 4'h8, ~{16'h0000, en8}, 4'hF, 33'h100000000);
        wb(1'b0, 4'hC, 32'h00000000, 4'hF, 33'h100000000);
        wb(1'b0, 4'h0, 32'h00000000, 4'hF, {17'h00000, en8});
        $display("test unmapped done");
        end_sim();
    end
endmodule : tie89_top_tb
`default_nettype wire
